// ---- src/prcc_pkg.sv ----
// constants shared by the clock and reset control block
package prcc_pkg;
   localparam int        CLK_MHZ          = 40;       // system clock rate
   localparam int        LOCK_REF_CYCLES  = 100000;   // reference cycles before lock is guaranteed
   localparam int        RESET_OUTPUT_N_BUS_CYCLES  = 16;       // extra bus clocks of reset_output_n after lock
   localparam int        LOCK_CNT_W       = 17;
   localparam int        EXT_CNT_W        = 8;
   // strap field positions on the data bus
   localparam int        RATIO_LSB        = 0;
   localparam int        RANGE_LSB        = 2;
   // bus ratio strap codes
   localparam logic [1:0] RATIO_QUARTER   = 2'h0;
   localparam logic [1:0] RATIO_UNUSED    = 2'h1;
   localparam logic [1:0] RATIO_HALF      = 2'h2;
   localparam logic [1:0] RATIO_THIRD     = 2'h3;
   // input range strap codes
   localparam logic [1:0] RANGE_LOW       = 2'h0;
   localparam logic [1:0] RANGE_UNUSED    = 2'h3;
   // divisors in core clock cycles
   localparam logic [2:0] DIV_QUARTER     = 3'h4;
   localparam logic [2:0] DIV_HALF        = 3'h2;
   localparam logic [2:0] DIV_THIRD       = 3'h3;
   // reset values
   localparam logic [1:0] RATIO_RST       = 2'h0;
   localparam logic [1:0] RANGE_RST       = 2'h0;

   typedef enum logic [3:0] {
      PRCC_RESET  = 4'h1,
      PRCC_LOCK   = 4'h2,
      PRCC_RSTEXT = 4'h4,
      PRCC_RUN    = 4'h8
   } prcc_state_e;
endpackage

// ---- src/prcc_top.sv ----
// clock and reset control: strap capture, lock wait, derived clocks and peripheral reset
// Notes on behaviour
// RL1: reference frequency is only taken into account at reset; lock wait restarts only there.
// RL2: while reset_input_n is low the block stays in reset and never starts lock.
// RL3: range strap comes from data bits 3:2 during reset; 00 low range, 11 unused.
// RL4: ratio strap from data bits 1:0; 00 quarter, 10 half, 11 third, 01 unused.
// RL5: bus_clock_out is the core clock divided by the strapped ratio.
// RL6: status_clock_out is a registered, delayed copy of the core clock.
// RL7: reset_output_n is the reset given to external peripherals.
// RL8: outside party holds reset_input_n low 80 reference cycles with straps driven.
// RL9: straps latched on the last bus clock rise before reset release; ramp then starts.
// RL10: bus and status clocks held low during ramp and lock, then toggle.
// RL11: lock is treated as guaranteed after 100,000 reference cycles from release.
// RL12: reset_output_n stays low some bus clocks after the clocks start.
// RL13: core clock runs at twice the reference clock frequency.
// RL14: reset_output_n is asserted whenever the block is in reset mode.
// RL15: number of extra bus clocks of peripheral reset is a design parameter.
`timescale 1ns/1ps
module prcc_top
   import prcc_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_REF_CYCLES,
   parameter int EXT_CYCLES  = RESET_OUTPUT_N_BUS_CYCLES
)(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       input_reference_clock,
   input  wire logic       reset_input_n,
   input  wire logic [7:0] data_bus_in,
   output logic            core_clock,
   output logic            bus_clock_out,
   output logic            status_clock_out,
   output logic            reset_output_n,
   output logic [1:0]      input_range_select,
   output logic [1:0]      bus_ratio_select,
   output logic            strap_unused_code,
   output logic            lock_done
);

   // every flop of the block lives in this one record; the three *_sync fields
   // are two-stage synchronisers, and only their second stage feeds any logic
   typedef struct packed {
      logic [1:0]            rst_sync;
      logic [1:0]            ref_sync;
      logic [15:0]           data_sync;
      logic                  ref_prev;
      prcc_state_e           st;
      logic                  core_ph;
      logic                  pst;
      logic                  bclk;
      logic [2:0]            bcnt;
      logic [1:0]            ratio;
      logic [1:0]            range;
      logic [LOCK_CNT_W-1:0] lock_cnt;
      logic [EXT_CNT_W-1:0]  ext_cnt;
   } prcc_regs_s;

   // registered state and the value it takes at the next edge
   prcc_regs_s state_r;
   prcc_regs_s state_nxt;

   // divisor in core clock periods for a ratio code; the unused code falls back to a quarter
   function automatic logic [2:0] prcc_div(input logic [1:0] code);
      logic [2:0] d;
      d = DIV_QUARTER;
      case (code)
         RATIO_HALF:    d = DIV_HALF;
         RATIO_THIRD:   d = DIV_THIRD;
         RATIO_QUARTER: d = DIV_QUARTER;
         default:       d = DIV_QUARTER;
      endcase
      return d;
   endfunction

   // decoded views of the registered state
   logic             rst_pin_low;
   logic             ref_rise;
   logic [1:0]       strap_ratio;
   logic [1:0]       strap_range;
   logic [2:0]       div_live;
   logic             bclk_wrap;

   // synchronised pin views; only the second stage is ever looked at
   // the reset pin is sampled, not truly asynchronous: a low pulse shorter than one clock may be missed
   assign rst_pin_low = ~state_r.rst_sync[1];
   assign ref_rise    = state_r.ref_sync[1] & ~state_r.ref_prev;
   assign strap_ratio = state_r.data_sync[8 + RATIO_LSB +: 2];
   assign strap_range = state_r.data_sync[8 + RANGE_LSB +: 2];
   assign div_live    = prcc_div(state_r.ratio);
   assign bclk_wrap   = (state_r.bcnt == (div_live - 3'h1));

   // next-state logic for the whole block
   always_comb
   begin
      state_nxt           = state_r;
      state_nxt.rst_sync  = {state_r.rst_sync[0], reset_input_n};
      state_nxt.ref_sync  = {state_r.ref_sync[0], input_reference_clock};
      state_nxt.data_sync = {state_r.data_sync[7:0], data_bus_in};
      state_nxt.ref_prev  = state_r.ref_sync[1];
      // core phase toggles every clk: core clock at twice a reference of clk/4
      state_nxt.core_ph   = ~state_r.core_ph; // RL13
      // half period of the bus clock is div clk cycles, so its rate is core / div
      state_nxt.bcnt      = bclk_wrap ? 3'h0 : state_r.bcnt + 3'h1; // RL5
      if (bclk_wrap)
      begin
         state_nxt.bclk = ~state_r.bclk; // RL5
      end
      state_nxt.pst = state_r.core_ph; // RL6
      // mode sequencing: reset, lock wait, peripheral reset extension, run
      case (state_r.st)
         PRCC_RESET:
         begin
            // straps refresh on every bus clock rise, so the last one before release wins
            if (bclk_wrap && !state_r.bclk)
            begin
               state_nxt.ratio = strap_ratio; // RL4 RL9
               state_nxt.range = strap_range; // RL3 RL9
            end
            // lock wait starts over from every reset, so a new reference rate is honoured
            state_nxt.lock_cnt = '0; // RL1
            state_nxt.ext_cnt  = '0;
            if (!rst_pin_low)
            begin
               state_nxt.st   = PRCC_LOCK; // RL9
               state_nxt.bclk = 1'b0;
               state_nxt.bcnt = 3'h0;
            end
         end
         PRCC_LOCK:
         begin
            // loop is ramping: both clocks parked low, lock counted in reference rises
            state_nxt.bclk = 1'b0; // RL10
            state_nxt.pst  = 1'b0; // RL10
            state_nxt.bcnt = 3'h0;
            if (ref_rise)
            begin
               if (state_r.lock_cnt == LOCK_CNT_W'(LOCK_CYCLES - 1))
               begin
                  state_nxt.st = PRCC_RSTEXT; // RL11
               end
               else
               begin
                  state_nxt.lock_cnt = state_r.lock_cnt + 1'b1; // RL11
               end
            end
         end
         PRCC_RSTEXT:
         begin
            // count bus clock rises while peripherals see a running clock under reset
            if (bclk_wrap && !state_r.bclk)
            begin
               if (state_r.ext_cnt == EXT_CNT_W'(EXT_CYCLES - 1))
               begin
                  state_nxt.st = PRCC_RUN; // RL12 RL15
               end
               else
               begin
                  state_nxt.ext_cnt = state_r.ext_cnt + 1'b1; // RL12
               end
            end
         end
         PRCC_RUN:
         begin
            // stays here until the reset pin drops again
            state_nxt.st = PRCC_RUN;
         end
         default:
         begin
            // a stray state code lands in reset mode rather than running unlocked
            state_nxt.st = PRCC_RESET;
         end
      endcase
      // reset pin overrides everything; lock never starts while it is low
      if (rst_pin_low)
      begin
         state_nxt.st = PRCC_RESET; // RL2
         if (state_r.st != PRCC_RESET)
         begin
            // bus clock restarts from low; a high phase already in progress is cut short
            state_nxt.bclk = 1'b0;
            state_nxt.bcnt = 3'h0;
         end
      end
   end

   // single register for all state
   // asynchronous reset loads constants only; the pin reset goes through the synchroniser instead
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         // synchroniser starts low, so the block wakes in reset mode
         state_r.rst_sync  <= 2'h0;
         state_r.ref_sync  <= 2'h0;
         state_r.data_sync <= 16'h0;
         state_r.ref_prev  <= 1'b0;
         state_r.st        <= PRCC_RESET;
         state_r.core_ph   <= 1'b0;
         state_r.pst       <= 1'b0;
         state_r.bclk      <= 1'b0;
         state_r.bcnt      <= 3'h0;
         state_r.ratio     <= RATIO_RST;
         state_r.range     <= RANGE_RST;
         state_r.lock_cnt  <= '0;
         state_r.ext_cnt   <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // outputs from flops, some through a decode of the registered state
   // status clock is gated by state so no stray pulse leaves during lock; reset out is a state decode
   assign core_clock         = state_r.core_ph;
   assign bus_clock_out      = state_r.bclk;
   assign status_clock_out   = state_r.pst & (state_r.st == PRCC_RSTEXT || state_r.st == PRCC_RUN); // RL10
   assign reset_output_n     = (state_r.st == PRCC_RUN); // RL7 RL14
   assign input_range_select = state_r.range;
   assign bus_ratio_select   = state_r.ratio;
   assign strap_unused_code  = (state_r.range == RANGE_UNUSED) | (state_r.ratio == RATIO_UNUSED); // RL3
   assign lock_done          = (state_r.st == PRCC_RSTEXT) | (state_r.st == PRCC_RUN);

endmodule // prcc_top

// ---- tb/prcc_assertions.sv ----
// port checker for the clock and reset control block
`timescale 1ns/1ps
module prcc_assertions
   import prcc_pkg::*;
#(
   parameter int LOCK_CYCLES = 5
)(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       reset_input_n,
   input wire logic       core_clock,
   input wire logic       bus_clock_out,
   input wire logic       status_clock_out,
   input wire logic       reset_output_n,
   input wire logic [1:0] input_range_select,
   input wire logic [1:0] bus_ratio_select,
   input wire logic       strap_unused_code,
   input wire logic       lock_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [19:0] hi_cnt_r;
   // cycles with the reset pin high; a low pin restarts the lock wait
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst) hi_cnt_r <= 20'h0;
      else hi_cnt_r <= reset_input_n ? hi_cnt_r + 20'h1 : 20'h0;
   a_reset_holds: assert property ((!reset_input_n)[*4] |-> !reset_output_n && !lock_done)
      else $error("block left reset while pin low");
   a_core_toggle: assert property (!$past(sys_rst) |-> core_clock != $past(core_clock))
      else $error("core clock missed a toggle");
   a_status_copy: assert property (lock_done && $past(lock_done) && $past(lock_done, 2)
      |-> status_clock_out == $past(core_clock))
      else $error("status clock not a delayed core copy");
   a_bus_lock_low: assert property (reset_input_n[*5] ##0 !lock_done |-> !bus_clock_out)
      else $error("bus clock toggled before lock");
   a_div_half: assert property (lock_done && $rose(bus_clock_out) && bus_ratio_select == RATIO_HALF
      |-> (bus_clock_out || !reset_output_n)[*2] ##1 !bus_clock_out)
      else $error("half ratio high phase wrong");
   a_div_third: assert property (lock_done && $rose(bus_clock_out) && bus_ratio_select == RATIO_THIRD
      |-> (bus_clock_out || !reset_output_n)[*3] ##1 !bus_clock_out)
      else $error("third ratio high phase wrong");
   a_div_quarter: assert property (lock_done && $rose(bus_clock_out) && !bus_ratio_select[1]
      |-> (bus_clock_out || !reset_output_n)[*4] ##1 !bus_clock_out)
      else $error("quarter ratio high phase wrong");
   a_reset_output_n_late: assert property ($rose(reset_output_n) |-> lock_done && $past(lock_done, 5))
      else $error("peripheral reset released too early");
   a_lock_time: assert property ($rose(lock_done)
      |-> int'(hi_cnt_r) >= 4 * LOCK_CYCLES - 4 && int'(hi_cnt_r) <= 4 * LOCK_CYCLES + 8)
      else $error("lock wait length wrong");
   a_strap_frozen: assert property (lock_done && $past(lock_done)
      |-> $stable(bus_ratio_select) && $stable(input_range_select))
      else $error("straps changed outside reset");
   a_unused_flag: assert property (strap_unused_code
      == (input_range_select == RANGE_UNUSED || bus_ratio_select == RATIO_UNUSED))
      else $error("unused strap flag wrong");
endmodule // prcc_assertions
bind prcc_top prcc_assertions #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.clk, .sys_rst, .reset_input_n, .core_clock,
   .bus_clock_out, .status_clock_out, .reset_output_n, .input_range_select, .bus_ratio_select,
   .strap_unused_code, .lock_done);

// ---- tb/prcc_board.sv ----
// board side: reference clock source at a fixed quarter of the system clock
`timescale 1ns/1ps
module prcc_board (
   input  wire logic clk,
   input  wire logic sys_rst,
   output logic      input_reference_clock
);
   logic [1:0] div_r;
   // rate never changes while running, the block only rereads it at reset
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst) div_r <= 2'h0;
      else div_r <= div_r + 2'h1;
   assign input_reference_clock = div_r[1];
endmodule // prcc_board

// ---- tb/prcc_top_tb.sv ----
// self-checking bench for the clock and reset control block
`timescale 1ns/1ps
module prcc_top_tb;
   import prcc_pkg::*;
   localparam int LK = 5;
   localparam int EX = 2;
   logic       clk, sys_rst, reset_input_n, input_reference_clock, core_clock, lock_done;
   logic       bus_clock_out, status_clock_out, reset_output_n, strap_unused_code, bad;
   logic [7:0] data_bus_in;
   logic [1:0] input_range_select, bus_ratio_select;
   int         num_errors = 0;
   int         checks = 0;
   prcc_board board_u (.clk, .sys_rst, .input_reference_clock);
   prcc_top #(.LOCK_CYCLES(LK), .EXT_CYCLES(EX)) dut_u (.clk, .sys_rst, .input_reference_clock, .reset_input_n,
      .data_bus_in, .core_clock, .bus_clock_out, .status_clock_out, .reset_output_n, .input_range_select,
      .bus_ratio_select, .strap_unused_code, .lock_done);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // full boot: straps under reset, optional abort during lock, then clocks and peripheral reset
   task automatic boot(input logic [1:0] rat, input logic [1:0] rng, input int dv, input bit ab);
      int n;
      @(posedge clk);
      reset_input_n <= 1'b0;
      data_bus_in <= {4'h0, rng, rat};
      repeat (330) @(posedge clk);
      reset_input_n <= 1'b1;
      if (ab)
      begin
         repeat (8) @(posedge clk);
         reset_input_n <= 1'b0;
         repeat (330) @(negedge clk);
         chk("lock in reset", 8'h0, {6'h0, lock_done, reset_output_n});
         @(posedge clk);
         reset_input_n <= 1'b1;
      end
      repeat (5) @(posedge clk);
      data_bus_in <= ~{4'h0, rng, rat};
      @(negedge clk);
      bad = 1'b0;
      for (n = 0; n < 4 * LK + 9 && lock_done !== 1'b1; n++)
      begin
         bad = bad | bus_clock_out | status_clock_out | reset_output_n;
         @(negedge clk);
      end
      chk("lock", 8'h1, {7'h0, lock_done});
      if (lock_done !== 1'b1) conclude();
      chk("lock early", 8'h1, {7'h0, n >= 4 * LK - 6});
      chk("held low", 8'h0, {7'h0, bad});
      chk("ratio", {6'h0, rat}, {6'h0, bus_ratio_select});
      chk("range", {6'h0, rng}, {6'h0, input_range_select});
      chk("unused", {7'h0, rng == RANGE_UNUSED || rat == RATIO_UNUSED}, {7'h0, strap_unused_code});
      for (n = 0; n < 60 && reset_output_n !== 1'b1; n++) @(negedge clk);
      chk("reset_output_n", 8'h1, {7'h0, reset_output_n});
      if (reset_output_n !== 1'b1) conclude();
      chk("reset_output_n delay", 8'h1, {7'h0, n >= (2 * EX - 1) * dv});
      for (n = 0; n < 9 && bus_clock_out !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 9 && bus_clock_out !== 1'b1; n++) @(negedge clk);
      for (n = 0; n < 9 && bus_clock_out === 1'b1; n++) @(negedge clk);
      chk("bus half", 8'(dv), 8'(n));
   endtask
   // quarter ratio from a clean power-up reset
   task automatic scen_quarter;
      boot(RATIO_QUARTER, RANGE_LOW, 4, 1'b0);
   endtask
   // half ratio with a full-length reset pulse dropped in the middle of the lock wait
   task automatic scen_half_abort;
      boot(RATIO_HALF, RANGE_LOW, 2, 1'b1);
   endtask
   // unused ratio code must run as a quarter and raise the flag
   task automatic scen_unused_ratio;
      boot(RATIO_UNUSED, RANGE_LOW, 4, 1'b0);
   endtask
   // third ratio
   task automatic scen_third;
      boot(RATIO_THIRD, RANGE_LOW, 3, 1'b0);
   endtask
   initial
   begin
      sys_rst = 1'b1;
      reset_input_n = 1'b0;
      data_bus_in = 8'h0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      scen_quarter();
      scen_half_abort();
      scen_unused_ratio();
      scen_third();
      conclude();
   end
endmodule // prcc_top_tb
